//--- rtl/cal_regs_cfg.svh
// Purpose: register indices, field positions, reset values and write masks
// Assumes: byte address is four times the register index
// Notes:   16-bit registers sit in the low half of each 32-bit word
`ifndef CAL_REGS_CFG_SVH
`define CAL_REGS_CFG_SVH

// ============================================================
// register indices
`define CAL_IDX_THRESH_LOW     6'h08
`define CAL_IDX_CH0_GAIN_LOW   6'h0d
`define CAL_IDX_CH1_CONFIG     6'h0e
`define CAL_IDX_CH1_OFS_HIGH   6'h0f
`define CAL_IDX_CH1_OFS_LOW    6'h10
`define CAL_IDX_CH1_GAIN_HIGH  6'h11
`define CAL_IDX_CH1_GAIN_LOW   6'h12

// ============================================================
// field positions
`define CAL_CFG_PHASE_MSB      15
`define CAL_CFG_PHASE_LSB      6
`define CAL_CFG_BYPASS_BIT     2
`define CAL_CFG_MUX_MSB        1
`define CAL_CFG_MUX_LSB        0
`define CAL_LOW_BYTE_MSB       15
`define CAL_LOW_BYTE_LSB       8
`define CAL_DC_SET_MSB         3
`define CAL_DC_SET_LSB         0

// ============================================================
// writable bits; everything else is reserved and stays zero
`define CAL_WMASK_THRESH_LOW   16'hff0f
`define CAL_WMASK_CONFIG       16'hffc7
`define CAL_WMASK_FULL         16'hffff
`define CAL_WMASK_UPPER_BYTE   16'hff00

// ============================================================
// reset values
`define CAL_RST_ZERO           16'h0000
`define CAL_RST_GAIN_HIGH      16'h8000

`endif

//--- rtl/cal_regs_pkg.sv
// Purpose: shared types of the calibration register bank
// Assumes: nothing beyond the cfg header
// Notes:   constants live in cal_regs_cfg.svh
package cal_regs_pkg;

  typedef logic [15:0] reg16_t;
  typedef logic [5:0]  reg_idx_t;
  typedef logic [23:0] cal24_t;

  // ============================================================
  // response codes
  typedef enum logic [1:0] {
    resp_okay_e   = 2'b00,
    resp_slverr_e = 2'b10
  } axi_resp_t;

endpackage : cal_regs_pkg

//--- rtl/cal_regs_if.sv
// Purpose: carries register accesses from the bus slave to the bank
// Assumes: one clock, all signals combinational within a cycle
// Notes:   hit answers come back in the same cycle as the enable
`timescale 1ns/1ps
interface cal_regs_if;
  import cal_regs_pkg::*;

  logic     wr_en;
  reg_idx_t wr_idx;
  reg16_t   wr_data;
  logic [1:0] wr_strb;
  logic     wr_hit;
  logic     rd_en;
  reg_idx_t rd_idx;
  reg16_t   rd_data;
  logic     rd_hit;

  modport bus (
    output wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx,
    input  wr_hit, rd_data, rd_hit
  );
  modport regs (
    input  wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx,
    output wr_hit, rd_data, rd_hit
  );
endinterface : cal_regs_if

//--- rtl/cal_axil_slave.sv
// Purpose: AXI4-Lite slave front end of the calibration bank
// Assumes: master and bank on i_mclk
// Notes:   write response two cycles after both halves, read data next cycle
`timescale 1ns/1ps
module cal_axil_slave (
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  // write address and data
  input  wire logic                   i_awvalid,
  output logic                        o_awready,
  input  wire logic [7:0]             i_awaddr,
  input  wire logic                   i_wvalid,
  output logic                        o_wready,
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_wstrb,
  // write response
  output logic                        o_bvalid,
  input  wire logic                   i_bready,
  output cal_regs_pkg::axi_resp_t     o_bresp,
  // read
  input  wire logic                   i_arvalid,
  output logic                        o_arready,
  input  wire logic [7:0]             i_araddr,
  output logic                        o_rvalid,
  input  wire logic                   i_rready,
  output logic [31:0]                 o_rdata,
  output cal_regs_pkg::axi_resp_t     o_rresp,
  // register side
  cal_regs_if.bus                     regs
);
  import cal_regs_pkg::*;

  logic       aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  reg_idx_t   aw_idx_r, aw_idx_nxt;
  reg16_t     w_data_r, w_data_nxt;
  logic [1:0] w_strb_r, w_strb_nxt;
  logic       bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  axi_resp_t  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic       do_wr;

  // ============================================================
  // handshakes
  assign o_awready = !aw_full_r;
  assign o_wready  = !w_full_r;
  // one read at a time: refuse a new address while data waits
  assign o_arready = !rvalid_r;
  assign do_wr     = aw_full_r && w_full_r && !bvalid_r;

  assign regs.wr_en   = do_wr;
  assign regs.wr_idx  = aw_idx_r;
  assign regs.wr_data = w_data_r;
  assign regs.wr_strb = w_strb_r;
  assign regs.rd_en   = i_arvalid && !rvalid_r;
  assign regs.rd_idx  = i_araddr[7:2];

  assign o_bvalid = bvalid_r;
  assign o_bresp  = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata  = rdata_r;
  assign o_rresp  = rresp_r;

  // ============================================================
  // next state
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_idx_nxt  = aw_idx_r;
    w_full_nxt  = w_full_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (i_awvalid && !aw_full_r) begin
      aw_full_nxt = 1'b1;
      aw_idx_nxt  = i_awaddr[7:2];
    end
    if (i_wvalid && !w_full_r) begin
      w_full_nxt = 1'b1;
      w_data_nxt = i_wdata[15:0];
      w_strb_nxt = i_wstrb[1:0];
    end
    if (bvalid_r && i_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = regs.wr_hit ? resp_okay_e : resp_slverr_e;
    end
    if (rvalid_r && i_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (regs.rd_en) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {16'h0000, regs.rd_data};
      rresp_nxt  = regs.rd_hit ? resp_okay_e : resp_slverr_e;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_full_r <= 1'b0;
      aw_idx_r  <= 6'h00;
      w_full_r  <= 1'b0;
      w_data_r  <= 16'h0000;
      w_strb_r  <= 2'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= resp_okay_e;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= resp_okay_e;
    end else begin
      aw_full_r <= aw_full_nxt;
      aw_idx_r  <= aw_idx_nxt;
      w_full_r  <= w_full_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

endmodule : cal_axil_slave

//--- rtl/adc_channel_calibration_regs.sv
// Purpose: channel 0 gain low word and channel 1 configuration and calibration
// Assumes: AXI4-Lite master on i_mclk; datapath reads the outputs below
// Notes:   unmapped indices answer SLVERR and read zero
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cal_regs_cfg.svh"
module adc_channel_calibration_regs (
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  // axi4-lite write address and data
  input  wire logic                   i_s_axi_awvalid,
  output logic                        o_s_axi_awready,
  input  wire logic [7:0]             i_s_axi_awaddr,
  input  wire logic                   i_s_axi_wvalid,
  output logic                        o_s_axi_wready,
  input  wire logic [31:0]            i_s_axi_wdata,
  input  wire logic [3:0]             i_s_axi_wstrb,
  // axi4-lite write response
  output logic                        o_s_axi_bvalid,
  input  wire logic                   i_s_axi_bready,
  output cal_regs_pkg::axi_resp_t     o_s_axi_bresp,
  // axi4-lite read
  input  wire logic                   i_s_axi_arvalid,
  output logic                        o_s_axi_arready,
  input  wire logic [7:0]             i_s_axi_araddr,
  output logic                        o_s_axi_rvalid,
  input  wire logic                   i_s_axi_rready,
  output logic [31:0]                 o_s_axi_rdata,
  output cal_regs_pkg::axi_resp_t     o_s_axi_rresp,
  // channel 0 settings
  output logic [7:0]                  o_ch0_gain_low_bits,
  // channel 1 settings
  output logic [9:0]                  o_ch1_phase_delay,
  output logic                        o_ch1_dc_filter_bypass,
  output logic [1:0]                  o_ch1_input_select,
  output cal_regs_pkg::cal24_t        o_ch1_offset_cal,
  output cal_regs_pkg::cal24_t        o_ch1_gain_cal,
  // global settings
  output logic [3:0]                  o_global_dc_filter_setting,
  output logic [7:0]                  o_threshold_low_bits
);
  import cal_regs_pkg::*;

  // ============================================================
  // helpers

  // byte strobes widened to a bit mask over the low half-word
  function automatic reg16_t strb_mask(input logic [1:0] strb);
    strb_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : strb_mask

  // only writable bits under an enabled lane change
  function automatic reg16_t merge16(input reg16_t old_v, input reg16_t new_v,
                                     input reg16_t wmask, input logic [1:0] strb);
    reg16_t m;
    m = wmask & strb_mask(strb);
    merge16 = (old_v & ~m) | (new_v & m);
  endfunction : merge16

  // high word holds bits 23:8, low word holds bits 7:0 in its upper byte
  function automatic cal24_t join24(input reg16_t hi, input reg16_t lo);
    join24 = {hi, lo[`CAL_LOW_BYTE_MSB:`CAL_LOW_BYTE_LSB]};
  endfunction : join24

  function automatic logic idx_mapped(input reg_idx_t idx);
    idx_mapped = (idx == `CAL_IDX_THRESH_LOW) ||
                 ((idx >= `CAL_IDX_CH0_GAIN_LOW) && (idx <= `CAL_IDX_CH1_GAIN_LOW));
  endfunction : idx_mapped

  // ============================================================
  // bus slave
  cal_regs_if acc ();

  cal_axil_slave u_slave (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_awvalid (i_s_axi_awvalid),
    .o_awready (o_s_axi_awready),
    .i_awaddr  (i_s_axi_awaddr),
    .i_wvalid  (i_s_axi_wvalid),
    .o_wready  (o_s_axi_wready),
    .i_wdata   (i_s_axi_wdata),
    .i_wstrb   (i_s_axi_wstrb),
    .o_bvalid  (o_s_axi_bvalid),
    .i_bready  (i_s_axi_bready),
    .o_bresp   (o_s_axi_bresp),
    .i_arvalid (i_s_axi_arvalid),
    .o_arready (o_s_axi_arready),
    .i_araddr  (i_s_axi_araddr),
    .o_rvalid  (o_s_axi_rvalid),
    .i_rready  (i_s_axi_rready),
    .o_rdata   (o_s_axi_rdata),
    .o_rresp   (o_s_axi_rresp),
    .regs      (acc.bus)
  );

  // ============================================================
  // register storage
  reg16_t thresh_low_r,    thresh_low_nxt;
  reg16_t ch0_gain_low_r,  ch0_gain_low_nxt;
  reg16_t ch1_config_r,    ch1_config_nxt;
  reg16_t ch1_ofs_high_r,  ch1_ofs_high_nxt;
  reg16_t ch1_ofs_low_r,   ch1_ofs_low_nxt;
  reg16_t ch1_gain_high_r, ch1_gain_high_nxt;
  reg16_t ch1_gain_low_r,  ch1_gain_low_nxt;

  logic wr_go;

  assign wr_go      = acc.wr_en;
  assign acc.wr_hit = idx_mapped(acc.wr_idx);
  assign acc.rd_hit = idx_mapped(acc.rd_idx);

  // ============================================================
  // write path
  // reserved bits are masked out, so they keep their zero reset value
  always_comb begin
    thresh_low_nxt    = thresh_low_r;
    ch0_gain_low_nxt  = ch0_gain_low_r;
    ch1_config_nxt    = ch1_config_r;
    ch1_ofs_high_nxt  = ch1_ofs_high_r;
    ch1_ofs_low_nxt   = ch1_ofs_low_r;
    ch1_gain_high_nxt = ch1_gain_high_r;
    ch1_gain_low_nxt  = ch1_gain_low_r;
    if (wr_go && (acc.wr_idx == `CAL_IDX_THRESH_LOW)) begin
      thresh_low_nxt = merge16(thresh_low_r, acc.wr_data,
                               `CAL_WMASK_THRESH_LOW, acc.wr_strb);
    end else if (wr_go && (acc.wr_idx == `CAL_IDX_CH0_GAIN_LOW)) begin
      ch0_gain_low_nxt = merge16(ch0_gain_low_r, acc.wr_data,
                                 `CAL_WMASK_UPPER_BYTE, acc.wr_strb);
    end else if (wr_go && (acc.wr_idx == `CAL_IDX_CH1_CONFIG)) begin
      ch1_config_nxt = merge16(ch1_config_r, acc.wr_data,
                               `CAL_WMASK_CONFIG, acc.wr_strb);
    end else if (wr_go && (acc.wr_idx == `CAL_IDX_CH1_OFS_HIGH)) begin
      ch1_ofs_high_nxt = merge16(ch1_ofs_high_r, acc.wr_data,
                                 `CAL_WMASK_FULL, acc.wr_strb);
    end else if (wr_go && (acc.wr_idx == `CAL_IDX_CH1_OFS_LOW)) begin
      ch1_ofs_low_nxt = merge16(ch1_ofs_low_r, acc.wr_data,
                                `CAL_WMASK_UPPER_BYTE, acc.wr_strb);
    end else if (wr_go && (acc.wr_idx == `CAL_IDX_CH1_GAIN_HIGH)) begin
      ch1_gain_high_nxt = merge16(ch1_gain_high_r, acc.wr_data,
                                  `CAL_WMASK_FULL, acc.wr_strb);
    end else if (wr_go && (acc.wr_idx == `CAL_IDX_CH1_GAIN_LOW)) begin
      ch1_gain_low_nxt = merge16(ch1_gain_low_r, acc.wr_data,
                                 `CAL_WMASK_UPPER_BYTE, acc.wr_strb);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      thresh_low_r    <= `CAL_RST_ZERO;
      ch0_gain_low_r  <= `CAL_RST_ZERO;
      ch1_config_r    <= `CAL_RST_ZERO;
      ch1_ofs_high_r  <= `CAL_RST_ZERO;
      ch1_ofs_low_r   <= `CAL_RST_ZERO;
      ch1_gain_high_r <= `CAL_RST_GAIN_HIGH;
      ch1_gain_low_r  <= `CAL_RST_ZERO;
    end else begin
      thresh_low_r    <= thresh_low_nxt;
      ch0_gain_low_r  <= ch0_gain_low_nxt;
      ch1_config_r    <= ch1_config_nxt;
      ch1_ofs_high_r  <= ch1_ofs_high_nxt;
      ch1_ofs_low_r   <= ch1_ofs_low_nxt;
      ch1_gain_high_r <= ch1_gain_high_nxt;
      ch1_gain_low_r  <= ch1_gain_low_nxt;
    end
  end

  // ============================================================
  // read path
  // unmapped indices read zero; the slave turns the miss into SLVERR
  always_comb begin
    if (acc.rd_idx == `CAL_IDX_THRESH_LOW) begin
      acc.rd_data = thresh_low_r & `CAL_WMASK_THRESH_LOW;
    end else if (acc.rd_idx == `CAL_IDX_CH0_GAIN_LOW) begin
      acc.rd_data = ch0_gain_low_r & `CAL_WMASK_UPPER_BYTE;
    end else if (acc.rd_idx == `CAL_IDX_CH1_CONFIG) begin
      acc.rd_data = ch1_config_r & `CAL_WMASK_CONFIG;
    end else if (acc.rd_idx == `CAL_IDX_CH1_OFS_HIGH) begin
      acc.rd_data = ch1_ofs_high_r;
    end else if (acc.rd_idx == `CAL_IDX_CH1_OFS_LOW) begin
      acc.rd_data = ch1_ofs_low_r & `CAL_WMASK_UPPER_BYTE;
    end else if (acc.rd_idx == `CAL_IDX_CH1_GAIN_HIGH) begin
      acc.rd_data = ch1_gain_high_r;
    end else if (acc.rd_idx == `CAL_IDX_CH1_GAIN_LOW) begin
      acc.rd_data = ch1_gain_low_r & `CAL_WMASK_UPPER_BYTE;
    end else begin
      acc.rd_data = `CAL_RST_ZERO;
    end
  end

  // ============================================================
  // settings to the datapath
  // the calibration words are live halves, so software writes high then low
  // and the datapath may see one mixed value in between
  assign o_ch0_gain_low_bits    = ch0_gain_low_r[`CAL_LOW_BYTE_MSB:`CAL_LOW_BYTE_LSB];
  assign o_ch1_phase_delay      = ch1_config_r[`CAL_CFG_PHASE_MSB:`CAL_CFG_PHASE_LSB];
  assign o_ch1_dc_filter_bypass = ch1_config_r[`CAL_CFG_BYPASS_BIT];
  assign o_ch1_input_select     = ch1_config_r[`CAL_CFG_MUX_MSB:`CAL_CFG_MUX_LSB];
  assign o_ch1_offset_cal       = join24(ch1_ofs_high_r, ch1_ofs_low_r);
  assign o_ch1_gain_cal         = join24(ch1_gain_high_r, ch1_gain_low_r);
  assign o_global_dc_filter_setting = thresh_low_r[`CAL_DC_SET_MSB:`CAL_DC_SET_LSB];
  assign o_threshold_low_bits   = thresh_low_r[`CAL_LOW_BYTE_MSB:`CAL_LOW_BYTE_LSB];

endmodule : adc_channel_calibration_regs

//--- test/adc_cal_monitor.sv
// Purpose: concurrent checks on the calibration bank ports
// Assumes: one clock domain, async active-low reset
// Notes:   read index is tracked from the read address handshake
`timescale 1ns/1ps
`include "cal_regs_cfg.svh"
module adc_cal_monitor (
  // clock and reset
  input logic                    i_mclk,
  input logic                    i_rst_n,
  // bus
  input logic                    i_s_axi_arvalid,
  input logic                    o_s_axi_arready,
  input logic [7:0]              i_s_axi_araddr,
  input logic                    o_s_axi_rvalid,
  input logic [31:0]             o_s_axi_rdata,
  input cal_regs_pkg::axi_resp_t o_s_axi_rresp,
  input logic                    o_s_axi_bvalid,
  // settings
  input logic [7:0]              o_ch0_gain_low_bits,
  input logic [9:0]              o_ch1_phase_delay,
  input logic                    o_ch1_dc_filter_bypass,
  input logic [1:0]              o_ch1_input_select,
  input cal_regs_pkg::cal24_t    o_ch1_offset_cal,
  input cal_regs_pkg::cal24_t    o_ch1_gain_cal,
  input logic [3:0]              o_global_dc_filter_setting
);
  import cal_regs_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  logic [5:0] rd_idx_r;
  logic       rd_ok;
  // ==========
  // read index tracking
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) rd_idx_r <= 6'h00;
    else if (i_s_axi_arvalid && o_s_axi_arready) rd_idx_r <= i_s_axi_araddr[7:2];
  end
  assign rd_ok = o_s_axi_rvalid && (o_s_axi_rresp == resp_okay_e);

  // ==========
  // assertions
  AST_CH0_LOW: assert property (rd_ok && rd_idx_r == `CAL_IDX_CH0_GAIN_LOW |->
    o_s_axi_rdata[15:0] == {o_ch0_gain_low_bits, 8'h00}) else $error("ch0 gain low mismatch");
  AST_CFG_RSV: assert property (rd_ok && rd_idx_r == `CAL_IDX_CH1_CONFIG |->
    o_s_axi_rdata[5:3] == 3'h0) else $error("config reserved bits set");
  AST_CFG_PHASE: assert property (rd_ok && rd_idx_r == `CAL_IDX_CH1_CONFIG |->
    o_s_axi_rdata[15:6] == o_ch1_phase_delay) else $error("phase delay mismatch");
  AST_CFG_BYPASS: assert property (rd_ok && rd_idx_r == `CAL_IDX_CH1_CONFIG |->
    o_s_axi_rdata[2] == o_ch1_dc_filter_bypass) else $error("bypass mismatch");
  AST_CFG_MUX: assert property (rd_ok && rd_idx_r == `CAL_IDX_CH1_CONFIG |->
    o_s_axi_rdata[1:0] == o_ch1_input_select) else $error("input select mismatch");
  AST_OFS_LOW: assert property (rd_ok && rd_idx_r == `CAL_IDX_CH1_OFS_LOW |->
    o_s_axi_rdata[15:0] == {o_ch1_offset_cal[7:0], 8'h00}) else $error("offset low mismatch");
  AST_GAIN_HIGH: assert property (rd_ok && rd_idx_r == `CAL_IDX_CH1_GAIN_HIGH |->
    o_s_axi_rdata[15:0] == o_ch1_gain_cal[23:8]) else $error("gain high mismatch");
  AST_DC_SET: assert property (rd_ok && rd_idx_r == `CAL_IDX_THRESH_LOW |->
    o_s_axi_rdata[7:0] == {4'h0, o_global_dc_filter_setting}) else $error("dc setting mismatch");
  AST_RST_GAIN: assert property ($rose(i_rst_n) |-> o_ch1_gain_cal == 24'h800000)
    else $error("gain reset value wrong");
  AST_HOLD: assert property (!$stable({o_ch1_offset_cal, o_ch1_gain_cal}) |-> o_s_axi_bvalid)
    else $error("calibration changed without a write");
  AST_READ_LAT: assert property (i_s_axi_arvalid && o_s_axi_arready |=>
    o_s_axi_rvalid && !o_s_axi_arready) else $error("read answer late");
  cover property (rd_ok && rd_idx_r == `CAL_IDX_CH1_CONFIG);
  cover property (o_s_axi_rvalid && o_s_axi_rresp == resp_slverr_e);
  cover property ($rose(o_s_axi_bvalid));
endmodule : adc_cal_monitor

bind adc_channel_calibration_regs adc_cal_monitor mon (.*);

//--- test/tb_adc_channel_calibration_regs.sv
// Purpose: directed bench for the calibration register bank
// Assumes: bus answers long before the watchdog
// Notes:   byte address is four times the register index
`timescale 1ns/1ps
`include "cal_regs_cfg.svh"
module tb_adc_channel_calibration_regs;
  import cal_regs_pkg::*;
  logic        i_mclk = 1'b0, i_rst_n = 1'b0;
  logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0;
  logic [3:0]  i_s_axi_wstrb = 4'h0;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic        o_s_axi_rvalid, o_ch1_dc_filter_bypass;
  logic [31:0] o_s_axi_rdata, rd;
  axi_resp_t   o_s_axi_bresp, o_s_axi_rresp, resp;
  logic [7:0]  o_ch0_gain_low_bits, o_threshold_low_bits;
  logic [9:0]  o_ch1_phase_delay;
  logic [1:0]  o_ch1_input_select;
  cal24_t      o_ch1_offset_cal, o_ch1_gain_cal;
  logic [3:0]  o_global_dc_filter_setting;
  int          fails = 0, samples_checked = 0;
  localparam reg_idx_t IDX[7] = '{6'h08, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12};
  localparam reg16_t RST[7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000, 16'h0};
  localparam reg16_t MSK[7] = '{16'hff0f, 16'hff00, 16'hffc7, 16'hffff, 16'hff00, 16'hffff,
                                16'hff00};

  adc_channel_calibration_regs uut (.*);
  always #10 i_mclk = ~i_mclk;

  // ==========
  // compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_resp(input axi_resp_t got, input axi_resp_t exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: response %b expected %b", $time, got, exp);
    end
  endtask : chk_resp
  task automatic wr(input reg_idx_t idx, input reg16_t d, input logic [3:0] s);
    bit aw_done, w_done, aw_hs, w_hs;
    @(posedge i_mclk);
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_awaddr <= {idx, 2'b00};
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_wdata <= {16'h0, d};
    i_s_axi_wstrb <= s;
    i_s_axi_bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(negedge i_mclk);
      aw_hs = !aw_done && o_s_axi_awready;
      w_hs = !w_done && o_s_axi_wready;
      @(posedge i_mclk);
      if (aw_hs) i_s_axi_awvalid <= 1'b0;
      if (w_hs) i_s_axi_wvalid <= 1'b0;
      aw_done |= aw_hs;
      w_done |= w_hs;
    end
    do @(negedge i_mclk); while (!o_s_axi_bvalid);
    resp = o_s_axi_bresp;
    @(posedge i_mclk);
    i_s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input reg_idx_t idx);
    @(posedge i_mclk);
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_araddr <= {idx, 2'b00};
    i_s_axi_rready <= 1'b1;
    do @(negedge i_mclk); while (!o_s_axi_arready);
    @(posedge i_mclk);
    i_s_axi_arvalid <= 1'b0;
    do @(negedge i_mclk); while (!o_s_axi_rvalid);
    rd = o_s_axi_rdata;
    resp = o_s_axi_rresp;
    @(posedge i_mclk);
    i_s_axi_rready <= 1'b0;
  endtask : rd_reg
  task automatic rd_chk(input reg_idx_t idx, input reg16_t exp);
    rd_reg(idx);
    chk(rd, {16'h0, exp});
    chk_resp(resp, resp_okay_e);
  endtask : rd_chk

  // ==========
  // scenarios
  task automatic test_reset;
    for (int i = 0; i < 7; i++) rd_chk(IDX[i], RST[i]);
    chk(32'(o_ch1_gain_cal), 32'h800000);
    chk(32'(o_ch1_offset_cal), 32'h0);
  endtask : test_reset
  task automatic test_reserved;
    for (int i = 0; i < 7; i++) begin
      wr(IDX[i], 16'hffff, 4'hf);
      chk_resp(resp, resp_okay_e);
      rd_chk(IDX[i], MSK[i]);
    end
    chk(32'(o_ch0_gain_low_bits), 32'hff);
    chk(32'(o_global_dc_filter_setting), 32'hf);
    chk(32'(o_threshold_low_bits), 32'hff);
  endtask : test_reserved
  task automatic test_config;
    reg16_t cfg;
    for (int m = 0; m < 4; m++) begin
      cfg = {10'h200 | 10'(m), 3'b111, m[0], m[1:0]};
      wr(`CAL_IDX_CH1_CONFIG, cfg, 4'h3);
      rd_chk(`CAL_IDX_CH1_CONFIG, cfg & 16'hffc7);
      chk(32'(o_ch1_phase_delay), 32'h200 | m);
      chk(32'(o_ch1_dc_filter_bypass), 32'(m[0]));
      chk(32'(o_ch1_input_select), 32'(m[1:0]));
    end
  endtask : test_config
  task automatic test_cal;
    wr(`CAL_IDX_CH1_OFS_HIGH, 16'h8001, 4'h3);
    wr(`CAL_IDX_CH1_OFS_LOW, 16'h12ab, 4'h3);
    chk(32'(o_ch1_offset_cal), 32'h800112);
    wr(`CAL_IDX_CH1_GAIN_HIGH, 16'h1234, 4'h3);
    wr(`CAL_IDX_CH1_GAIN_LOW, 16'h56cd, 4'h3);
    chk(32'(o_ch1_gain_cal), 32'h123456);
    wr(`CAL_IDX_CH1_GAIN_LOW, 16'h99ff, 4'h1);
    rd_chk(`CAL_IDX_CH1_GAIN_LOW, 16'h5600);
    wr(`CAL_IDX_CH1_GAIN_LOW, 16'h7800, 4'h2);
    chk(32'(o_ch1_gain_cal), 32'h123478);
  endtask : test_cal
  task automatic test_unmapped;
    wr(6'h13, 16'hffff, 4'hf);
    chk_resp(resp, resp_slverr_e);
    rd_reg(6'h00);
    chk(rd, 32'h0);
    chk_resp(resp, resp_slverr_e);
    chk(32'(o_ch1_gain_cal), 32'h123478);
  endtask : test_unmapped
  // reset in mid-run must bring every setting back, gain high to 8000h
  task automatic test_midreset;
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    test_reset();
  endtask : test_midreset

  // ==========
  // verdict; the watchdog span is far above the few hundred cycles used
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #200us;
    fails++;
    $display("Error %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    test_reset();
    test_reserved();
    test_config();
    test_cal();
    test_unmapped();
    test_midreset();
    final_report();
  end
endmodule : tb_adc_channel_calibration_regs
